//--- wmc_cfg.svh
`ifndef WMC_CFG_SVH
`define WMC_CFG_SVH

// Register reset value and serial frame layout
`define WMC_CTRL_RESET 32'h7f8be110
`define WMC_CTRL_ADDR 4'h5
`define WMC_ADDR_W 4
`define WMC_FRAME_BITS 6'h25
`define WMC_ADDR_DONE 6'h05

// Field positions of the wake-up control word
`define WMC_WAKE_ON_BIT 31
`define WMC_DATA_BIT 30
`define WMC_STOP_BIT 29
`define WMC_LEN_HI 28
`define WMC_LEN_LO 24
`define WMC_ADDR_BIT 23
`define WMC_ERRCHK_BIT 22
`define WMC_SCAN_HI 21
`define WMC_SCAN_LO 13
`define WMC_RSSI_HI 12
`define WMC_RSSI_LO 6
`define WMC_HDR_HI 5
`define WMC_HDR_LO 3
`define WMC_STUFF_BIT 2

// Timing: clock period, one millisecond, scan and delay units
`define WMC_CLK_NS 20
`define WMC_MS_NS 1000000
`define WMC_SCAN_UNIT_MS 16'h000a
`define WMC_RSSI_UNIT_MS 16'h0008

`endif

//--- wmc_host_model.sv
`timescale 1ns/100ps
// Host side of the serial register pins; clock idles low between frames
module wmc_host_model (
	input wire logic i_sys_clk,
	input wire logic i_line,
	output logic o_clk,
	output logic o_en,
	output logic o_drv,
	output logic o_d
);
	initial begin
		o_clk = 0;
		o_en = 0;
		o_drv = 0;
		o_d = 0;
	end
	task automatic tick(input int k);
		repeat (k) @(posedge i_sys_clk);
		#1;
	endtask : tick
	// One frame: flag, address, 32 data bits, MSB first; reads release the line
	task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] r);
		logic [36:0] fr;
		fr = {w, a, d};
		o_en = 1;
		o_drv = 1;
		tick(4);
		for (int i = 36; i >= 0; i--) begin
			o_d = fr[i];
			o_drv = w || i > 31;
			tick(4);
			o_clk = 1;
			if (i < 32)
				r[i] = i_line;
			tick(4);
			o_clk = 0;
		end
		tick(4);
		o_en = 0;
		o_drv = 0;
		tick(6);
	endtask : xfer
endmodule : wmc_host_model

//--- wmc_pkg.sv
package wmc_pkg;
	// Wake-up sequence states
	typedef enum logic [1:0] {
		WMC_IDLE = 2'b00,
		WMC_SCAN = 2'b01,
		WMC_RSSI_WAIT = 2'b10,
		WMC_HDR_WAIT = 2'b11
	} wmc_state_t;
endpackage : wmc_pkg

//--- wmc_timer.sv
`timescale 1ns/100ps
`include "wmc_cfg.svh"

module wmc_timer import wmc_pkg::*; #(
	parameter int P_MS_CYCLES = `WMC_MS_NS / `WMC_CLK_NS
) (
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_enable,
	input wire logic [8:0] i_scan_interval,
	input wire logic [6:0] i_rssi_check_delay,
	input wire logic [2:0] i_header_check_delay,
	output logic o_osc_start,
	output logic o_signal_level_test,
	output logic o_header_detect_test
);
	// Stand-in for the on-chip RC oscillator: one tick each millisecond
	logic [31:0] pre_reg;
	logic ms_tick;
	// Phase change; restarts the millisecond count so each delay is whole
	logic restart;
	assign ms_tick = (pre_reg == 32'(P_MS_CYCLES - 1));

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			pre_reg <= 32'h00000000;
		end else if (restart) begin
			// A free-running tick could end a phase up to one millisecond early
			pre_reg <= 32'h00000000;
		end else begin
			pre_reg <= ms_tick ? 32'h00000000 : pre_reg + 32'h00000001;
		end
	end

	// Prescaler of 1, 16 or 256 taken from the top two interval bits
	logic [15:0] presc;
	assign presc = (i_scan_interval[8:7] == 2'b00) ? 16'h0001 :
		(i_scan_interval[8:7] == 2'b11) ? 16'h0100 : 16'h0010;

	// Targets in milliseconds; products fit 32 bits with margin
	logic [31:0] scan_ms;
	logic [31:0] rssi_ms;
	logic [31:0] hdr_ms;
	assign scan_ms = (32'(presc) * 32'(i_scan_interval[6:0]) + 32'h1)
		* 32'(`WMC_SCAN_UNIT_MS);
	assign rssi_ms = (32'(i_rssi_check_delay) + 32'h1) * 32'(`WMC_RSSI_UNIT_MS);
	assign hdr_ms = rssi_ms * 32'(i_header_check_delay);

	wmc_state_t state_reg;
	wmc_state_t state_next;
	logic [31:0] cnt_reg;
	logic [31:0] target;
	logic reached;
	assign target = (state_reg == WMC_SCAN) ? scan_ms :
		(state_reg == WMC_RSSI_WAIT) ? rssi_ms : hdr_ms;
	// Millisecond count has reached the target of the current phase
	assign reached = (cnt_reg >= target);
	assign restart = (state_next != state_reg);

	// Next state: scan, then start oscillator, then the two checks
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			WMC_IDLE: state_next = i_enable ? WMC_SCAN : WMC_IDLE;
			WMC_SCAN: state_next = reached ? WMC_RSSI_WAIT : WMC_SCAN;
			WMC_RSSI_WAIT: state_next = reached ? WMC_HDR_WAIT : WMC_RSSI_WAIT;
			WMC_HDR_WAIT: state_next = reached ? WMC_SCAN : WMC_HDR_WAIT;
		endcase
		if (!i_enable) begin
			// Disabling aborts any scan in progress
			state_next = WMC_IDLE;
		end
	end

	// Counter restarts on each phase change, so the first delay is counted
	// from the oscillator start and not from the last millisecond tick
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg <= WMC_IDLE;
			cnt_reg <= 32'h00000000;
		end else begin
			state_reg <= state_next;
			if (state_next != state_reg) begin
				cnt_reg <= 32'h00000000;
			end else if (ms_tick) begin
				cnt_reg <= cnt_reg + 32'h00000001;
			end
		end
	end

	// One-cycle event pulses on phase exits
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_osc_start <= 1'b0;
			o_signal_level_test <= 1'b0;
			o_header_detect_test <= 1'b0;
		end else begin
			o_osc_start <= i_enable && (state_reg == WMC_SCAN) && reached;
			o_signal_level_test <= i_enable && (state_reg == WMC_RSSI_WAIT) && reached;
			o_header_detect_test <= i_enable && (state_reg == WMC_HDR_WAIT) && reached;
		end
	end
endmodule : wmc_timer

//--- wmc_top.sv
`timescale 1ns/100ps
`include "wmc_cfg.svh"

module wmc_top import wmc_pkg::*; #(
	parameter int P_MS_CYCLES = `WMC_MS_NS / `WMC_CLK_NS
) (
	// System clock and asynchronous reset
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	// Serial register pins, asynchronous to the system clock
	input wire logic i_ser_clk,
	input wire logic i_ser_en,
	input wire logic i_ser_data,
	// Valid wake-up message from the receiver, same clock
	input wire logic i_msg_valid,
	// Serial read data and its pin enable, low while driving
	output logic o_ser_data,
	output logic o_ser_data_oe_n,
	// Configuration fields, each a copy of the stored register
	output logic o_wake_function_on,
	output logic o_data_present,
	output logic o_stop_mode,
	output logic [4:0] o_payload_length_code,
	output logic o_addr_present,
	output logic o_msg_error_check_mode,
	output logic o_bit_stuff_inhibit,
	// One-cycle timer events
	output logic o_osc_start,
	output logic o_signal_level_test,
	output logic o_header_detect_test
);
	// Two-stage synchronisers for the serial pins
	// Bit 2 serial clock, bit 1 frame enable, bit 0 serial data
	logic [2:0] sync1_reg;
	// First stage may go metastable; only this second stage is read
	logic [2:0] sync2_reg;
	// Delayed copies reset low like the idle pins, so no false edge
	logic sclk_d_reg;
	logic en_d_reg;
	// Raw pins are read by the first stage and nothing else

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
		end else begin
			sync1_reg <= {i_ser_clk, i_ser_en, i_ser_data};
			sync2_reg <= sync1_reg;
		end
	end

	// Previous values of the synced clock and enable for edge detection
	// One cycle of delay is enough, the synced lines are already clean
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sclk_d_reg <= 1'b0;
			en_d_reg <= 1'b0;
		end else begin
			sclk_d_reg <= sync2_reg[2];
			en_d_reg <= sync2_reg[1];
		end
	end

	// Edge decode of the synced serial lines
	// Clock edges count only inside a frame
	wire sclk_rise = sync2_reg[2] && !sclk_d_reg && sync2_reg[1];
	wire sclk_fall = !sync2_reg[2] && sclk_d_reg && sync2_reg[1];
	// Frame boundaries from the enable level
	wire frame_start = sync2_reg[1] && !en_d_reg;
	wire frame_end = !sync2_reg[1] && en_d_reg;

	// Frame: write flag, address, then 32 data bits, MSB first
	// Bits received so far; stops at a full frame
	logic [5:0] bit_cnt_reg;
	// Flag, address and data as shifted in
	logic [36:0] shift_reg;
	// Outgoing read word, bit 31 leaves first
	logic [31:0] rd_shift_reg;
	// The wake-up control register itself
	logic [31:0] ctrl_reg;

	// Address and direction, meaningful once five bits are in
	wire addr_hit = (shift_reg[3:0] == `WMC_CTRL_ADDR);
	wire is_read = !shift_reg[4];
	// Read word captured on the fifth rising edge, ahead of the falling
	// edge that must already show bit 31
	wire rd_load = sclk_rise && (bit_cnt_reg == `WMC_ADDR_DONE - 6'h01)
		&& !shift_reg[3] && ({shift_reg[2:0], sync2_reg[0]} == `WMC_CTRL_ADDR);
	// Write commits only for a full-length write frame to our address;
	// a short frame is dropped whole, never half applied; a long one commits its first 37 bits
	wire wr_commit = frame_end && (bit_cnt_reg == `WMC_FRAME_BITS)
		&& shift_reg[36] && (shift_reg[35:32] == `WMC_CTRL_ADDR);

	// First falling edge after the address starts a read to this register
	wire rd_start = sclk_fall && (bit_cnt_reg == `WMC_ADDR_DONE) && is_read && addr_hit;
	// Later falling edges while the pin is driven step to the next bit
	wire rd_step = sclk_fall && !o_ser_data_oe_n;
	wire rd_shift_en = rd_start || rd_step;

	// Bit counter and input shifter
	// Every bit is shifted, reads too; bits past a full frame are dropped,
	// so a long frame keeps the full-frame count and commits its first 37 bits
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			bit_cnt_reg <= 6'h00;
			shift_reg <= 37'h0;
		end else if (frame_start) begin
			bit_cnt_reg <= 6'h00;
		end else if (sclk_rise && bit_cnt_reg != `WMC_FRAME_BITS) begin
			bit_cnt_reg <= bit_cnt_reg + 6'h01;
			shift_reg <= {shift_reg[35:0], sync2_reg[0]};
		end
	end

	// Read path: live register copied once address is known
	// The copy is taken before the data phase, so a write or a wake-up
	// landing mid-read cannot tear the word on the pin
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rd_shift_reg <= 32'h00000000;
			o_ser_data <= 1'b0;
			o_ser_data_oe_n <= 1'b1;
		end else begin
			if (rd_load) begin
				rd_shift_reg <= ctrl_reg;
			end else if (rd_shift_en) begin
				// Shift as each bit goes out, so the next fall shows the next bit
				rd_shift_reg <= {rd_shift_reg[30:0], 1'b0};
			end
			// Pin data changes on falling edges; the host samples on rising ones
			if (rd_shift_en) begin
				o_ser_data <= rd_shift_reg[31];
			end
			// Drive only during the data phase of a read to this register
			if (!sync2_reg[1]) begin
				// Frame over: release the pin at once
				o_ser_data_oe_n <= 1'b1;
			end else if (rd_start) begin
				o_ser_data_oe_n <= 1'b0;
			end
		end
	end

	// Control register; a valid message clearing the enable beats a write
	// that lands in the same cycle, so a wake-up is never masked
	logic [31:0] ctrl_next;
	always_comb begin
		// Software write first, then the hardware clear on top of it
		ctrl_next = wr_commit ? shift_reg[31:0] : ctrl_reg;
		if (i_msg_valid) begin
			ctrl_next[`WMC_WAKE_ON_BIT] = 1'b0;
		end
	end

	// Register storage; reserved low bits keep whatever software writes,
	// so software has to write them as zero
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl_reg <= `WMC_CTRL_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// Configuration outputs registered from the next value, so each output
	// equals the matching register field in every cycle
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			// Reset values mirror the register reset word field by field
			o_wake_function_on <= 1'b0;
			o_data_present <= 1'b1;
			o_stop_mode <= 1'b1;
			o_payload_length_code <= 5'h1f;
			o_addr_present <= 1'b1;
			o_msg_error_check_mode <= 1'b0;
			o_bit_stuff_inhibit <= 1'b0;
		end else begin
			// Enable drops the cycle after a valid message
			o_wake_function_on <= ctrl_next[`WMC_WAKE_ON_BIT];
			o_data_present <= ctrl_next[`WMC_DATA_BIT];
			// Stop mode set: receiver finds the length from the stop field
			o_stop_mode <= ctrl_next[`WMC_STOP_BIT];
			// Code means bit count minus one; receiver uses it in fixed mode
			o_payload_length_code <= ctrl_next[`WMC_LEN_HI:`WMC_LEN_LO];
			o_addr_present <= ctrl_next[`WMC_ADDR_BIT];
			o_msg_error_check_mode <= ctrl_next[`WMC_ERRCHK_BIT];
			o_bit_stuff_inhibit <= ctrl_next[`WMC_STUFF_BIT];
		end
	end

	// Periodic scan and check sequencer
	// Fed from the stored register, so it reacts to a committed write or a valid-message clear
	// and never to a half-shifted frame
	wmc_timer #(
		.P_MS_CYCLES(P_MS_CYCLES)
	) u_timer (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_enable(ctrl_reg[`WMC_WAKE_ON_BIT]),
		.i_scan_interval(ctrl_reg[`WMC_SCAN_HI:`WMC_SCAN_LO]),
		.i_rssi_check_delay(ctrl_reg[`WMC_RSSI_HI:`WMC_RSSI_LO]),
		.i_header_check_delay(ctrl_reg[`WMC_HDR_HI:`WMC_HDR_LO]),
		.o_osc_start(o_osc_start),
		.o_signal_level_test(o_signal_level_test),
		.o_header_detect_test(o_header_detect_test)
	);
endmodule : wmc_top

//--- wmc_top_monitor.sv
`timescale 1ns/100ps
// Port-level checks on the wake-up control block
module wmc_top_monitor #(
	parameter int P_MS_CYCLES = 4
) (
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_ser_en,
	input wire logic i_msg_valid,
	input wire logic o_ser_data_oe_n,
	input wire logic o_wake_function_on,
	input wire logic o_data_present,
	input wire logic o_stop_mode,
	input wire logic [4:0] o_payload_length_code,
	input wire logic o_addr_present,
	input wire logic o_msg_error_check_mode,
	input wire logic o_bit_stuff_inhibit,
	input wire logic o_osc_start,
	input wire logic o_signal_level_test,
	input wire logic o_header_detect_test
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);
	// Cycles since the last scan tick
	int since_reg;
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst)
			since_reg <= 0;
		else if (o_osc_start)
			since_reg <= 0;
		else
			since_reg <= since_reg + 1;
	end
	a_valid_clears_on: assert property (i_msg_valid |=> !o_wake_function_on)
		else $error("enable kept after valid message");
	a_idle_no_drive: assert property (!i_ser_en [*4] |-> o_ser_data_oe_n)
		else $error("data pin driven outside frame");
	a_off_no_scan: assert property (!o_wake_function_on [*3] |-> !o_osc_start)
		else $error("scan tick while disabled");
	a_off_no_level: assert property (!o_wake_function_on [*3] |-> !o_signal_level_test)
		else $error("level test while disabled");
	a_off_no_header: assert property (!o_wake_function_on [*3] |-> !o_header_detect_test)
		else $error("header test while disabled");
	a_scan_one_pulse: assert property (o_osc_start |=> !o_osc_start)
		else $error("scan tick longer than a cycle");
	a_level_after_osc: assert property (o_signal_level_test |-> since_reg >= 8 * P_MS_CYCLES - 1)
		else $error("level test too early");
	a_fields_hold: assert property (!i_ser_en [*6] |-> $stable({o_data_present,
		o_stop_mode, o_payload_length_code, o_addr_present, o_msg_error_check_mode,
		o_bit_stuff_inhibit}))
		else $error("field changed without a write");
endmodule : wmc_top_monitor

bind wmc_top wmc_top_monitor #(.P_MS_CYCLES(P_MS_CYCLES)) u_mon (
	.i_sys_clk, .i_nrst, .i_ser_en, .i_msg_valid, .o_ser_data_oe_n, .o_wake_function_on,
	.o_data_present, .o_stop_mode, .o_payload_length_code, .o_addr_present,
	.o_msg_error_check_mode, .o_bit_stuff_inhibit, .o_osc_start, .o_signal_level_test,
	.o_header_detect_test
);

//--- wmc_top_tb.sv
`timescale 1ns/100ps
`include "wmc_cfg.svh"
module wmc_top_tb;
	logic i_sys_clk, i_nrst, i_msg_valid, s_clk, s_en, h_drv, h_d, line_d, o_ser_data, oe_n;
	logic wk, dat, stp, adr, err, stf, osc, lvl, hdr;
	logic [4:0] len;
	logic [31:0] rd, seen;
	logic [31:0] words [3] = '{32'h0000_0000, 32'h5e43_fe84, 32'h0f80_0000};
	int n_fail = 0;
	int checks_done = 0;
	int n;
	// Pull-up holds the shared line high when nobody drives it
	assign line_d = h_drv ? h_d : (oe_n ? 1'b1 : o_ser_data);
	assign seen = {21'h0, wk, dat, stp, len, adr, err, stf};
	wmc_host_model host (.i_sys_clk, .i_line(line_d), .o_clk(s_clk), .o_en(s_en),
		.o_drv(h_drv), .o_d(h_d));
	wmc_top #(.P_MS_CYCLES(4)) dut (.i_sys_clk, .i_nrst, .i_ser_clk(s_clk), .i_ser_en(s_en),
		.i_ser_data(line_d), .i_msg_valid, .o_ser_data, .o_ser_data_oe_n(oe_n),
		.o_wake_function_on(wk), .o_data_present(dat), .o_stop_mode(stp),
		.o_payload_length_code(len), .o_addr_present(adr), .o_msg_error_check_mode(err),
		.o_bit_stuff_inhibit(stf), .o_osc_start(osc), .o_signal_level_test(lvl),
		.o_header_detect_test(hdr));
	initial begin
		i_sys_clk = 0;
		forever #10 i_sys_clk = ~i_sys_clk;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH at %0t: saw %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results
	function automatic logic [31:0] flds(input logic [31:0] w);
		return {21'h0, w[31:22], w[2]};
	endfunction : flds
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, rd);
	endtask : wr
	task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
		host.xfer(1'b0, a, 32'h0, rd);
		chk(rd, e);
	endtask : rdchk
	// Bounded wait for a timer pulse: 0 scan, 1 level, 2 header
	task automatic waitp(input int sel);
		logic hit;
		for (n = 0; n < 600; n++) begin
			@(posedge i_sys_clk);
			#1;
			hit = (sel == 0) ? osc : ((sel == 1) ? lvl : hdr);
			if (hit === 1'b1)
				break;
		end
		if (n >= 600) begin
			chk(0, 1);
			results();
		end
	endtask : waitp
	initial begin
		i_nrst = 0;
		i_msg_valid = 0;
		repeat (5) @(posedge i_sys_clk);
		#1;
		i_nrst = 1;
		repeat (3) @(posedge i_sys_clk);
		#1;
		chk(seen, flds(`WMC_CTRL_RESET));
		rdchk(`WMC_CTRL_ADDR, `WMC_CTRL_RESET);
		// Fixed lengths with codes 0, 30 and 15, reserved bits kept zero
		foreach (words[i]) begin
			wr(`WMC_CTRL_ADDR, words[i]);
			chk(seen, flds(words[i]));
			rdchk(`WMC_CTRL_ADDR, words[i]);
		end
		// Another address is ignored and never drives the line
		wr(4'h6, 32'h0);
		rdchk(`WMC_CTRL_ADDR, words[2]);
		rdchk(4'h6, 32'hffff_ffff);
		// Stop-delimited length needs all ones in the length code
		wr(`WMC_CTRL_ADDR, 32'hff80_0008);
		chk(wk, 1);
		waitp(0);
		waitp(1);
		// First delay code 0 is 8 ms, 4 cycles each, from the scan tick
		chk(n >= 32, 1);
		waitp(2);
		i_msg_valid = 1;
		@(posedge i_sys_clk);
		#1;
		i_msg_valid = 0;
		@(posedge i_sys_clk);
		#1;
		chk(wk, 0);
		rdchk(`WMC_CTRL_ADDR, 32'h7f80_0008);
		repeat (100) @(posedge i_sys_clk);
		results();
	end
endmodule : wmc_top_tb
